// ### mfsb_bank.sv
// What this block does
// - driver word bit 31 is OR of all driver fault flags.
// - driver bit 30 reads 1 until power-up is seen, then 0; it is live, not latched.
// - driver bit 28 shows drain-source overcurrent.
// - driver bit 27 shows shunt overcurrent trip.
// - driver bit 26 shows bootstrap supply undervoltage.
// - driver bit 25 shows gate-drive supply undervoltage.
// - driver bit 24 shows independent shutdown state.
// - controller word bit 31 is OR of all controller fault flags.
// - controller bits 29 and 28 show position-detect rate and interval faults.
// - controller bit 23 shows abnormal-speed lock.
// - controller bit 22 shows sync-lost lock.
// - controller bit 21 shows no motor connected.
// - controller bit 20 set when any lock detector triggered.
// - controller bit 19 shows cycle-by-cycle current limit fault.
// - controller bit 18 shows lock current limit fault.
// - controller bits 17 and 16 show supply under and overvoltage.
// - controller bit 2 shows self-test enabled in configuration.
// - controller bit 1 shows self-test passed.
// - controller bit 0 shows application reset succeeded.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mfsb_bank (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire mfsb_pkg::mfsb_events_t events_i,
  input wire mfsb_pkg::mfsb_sys_t sys_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] gd_config_two_o,
  output logic clear_all_faults_o
);

  // detector levels come from another domain: two flops before use
  mfsb_pkg::mfsb_events_t ev_meta;
  mfsb_pkg::mfsb_events_t ev_sync;
  mfsb_pkg::mfsb_sys_t sys_meta;
  mfsb_pkg::mfsb_sys_t sys_sync;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_meta <= '0;
      ev_sync <= '0;
      sys_meta <= '0;
      sys_sync <= '0;
    end else begin
      ev_meta <= events_i;
      ev_sync <= ev_meta;
      sys_meta <= sys_i;
      sys_sync <= sys_meta;
    end
  end

  // latched fault flags; set wins over the clear-all request
  logic [15:0] latch;
  logic [15:0] raw_fault;
  logic [15:0] next_latch;
  logic clear_req;

  assign raw_fault = {ev_sync.switch_drop_overcurrent, ev_sync.shunt_overcurrent,
                      ev_sync.bootstrap_low_supply, ev_sync.gate_supply_low,
                      ev_sync.shutdown_pin, ev_sync.position_detect_rate_error,
                      ev_sync.position_detect_interval_error, ev_sync.abnormal_speed_lock,
                      ev_sync.sync_lost_lock, ev_sync.motor_absent,
                      ev_sync.cycle_current_limit, ev_sync.lock_current_limit,
                      ev_sync.supply_too_low, ev_sync.supply_too_high, 2'b00};
  assign next_latch = (clear_req ? 16'h0000 : latch) | raw_fault;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch <= 16'h0000;
    end else begin
      latch <= next_latch;
    end
  end

  wire logic switch_drop_overcurrent = latch[15];
  wire logic shunt_overcurrent = latch[14];
  wire logic bootstrap_low_supply = latch[13];
  wire logic gate_supply_low = latch[12];
  wire logic driver_shutdown_seen = latch[11];
  wire logic position_detect_rate_error = latch[10];
  wire logic position_detect_interval_error = latch[9];
  wire logic abnormal_speed_lock = latch[8];
  wire logic sync_lost_lock = latch[7];
  wire logic motor_absent = latch[6];
  wire logic cycle_current_limit = latch[5];
  wire logic lock_current_limit = latch[4];
  wire logic supply_too_low = latch[3];
  wire logic supply_too_high = latch[2];
  wire logic any_lock_tripped = abnormal_speed_lock | sync_lost_lock | motor_absent;

  // driver fault word
  logic [31:0] drv_word;
  always_comb begin
    drv_word = 32'h0000_0000;
    drv_word[mfsb_pkg::DF_POWER_UP] = ~ev_sync.power_up_seen;
    drv_word[mfsb_pkg::DF_SWITCH_OC] = switch_drop_overcurrent;
    drv_word[mfsb_pkg::DF_SHUNT_OC] = shunt_overcurrent;
    drv_word[mfsb_pkg::DF_BOOT_LOW] = bootstrap_low_supply;
    drv_word[mfsb_pkg::DF_GATE_LOW] = gate_supply_low;
    drv_word[mfsb_pkg::DF_SHUTDOWN] = driver_shutdown_seen;
    // power-up bit is a status, not a fault, so it stays out of the summary
    drv_word[mfsb_pkg::DF_SUMMARY] = |latch[15:11];
  end

  // controller fault word
  logic [31:0] ctl_word;
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[mfsb_pkg::CF_IPD_RATE] = position_detect_rate_error;
    ctl_word[mfsb_pkg::CF_IPD_INTERVAL] = position_detect_interval_error;
    ctl_word[mfsb_pkg::CF_ABNORMAL_SPEED_LOCK] = abnormal_speed_lock;
    ctl_word[mfsb_pkg::CF_SYNC_LOST] = sync_lost_lock;
    ctl_word[mfsb_pkg::CF_MOTOR_ABSENT] = motor_absent;
    ctl_word[mfsb_pkg::CF_ANY_LOCK] = any_lock_tripped;
    ctl_word[mfsb_pkg::CF_CYCLE_LIMIT] = cycle_current_limit;
    ctl_word[mfsb_pkg::CF_LOCK_LIMIT] = lock_current_limit;
    ctl_word[mfsb_pkg::CF_SUPPLY_LOW] = supply_too_low;
    ctl_word[mfsb_pkg::CF_SUPPLY_HIGH] = supply_too_high;
    ctl_word[mfsb_pkg::CF_SELFTEST_EN] = ev_sync.selftest_enabled;
    ctl_word[mfsb_pkg::CF_SELFTEST_OK] = ev_sync.selftest_passed;
    ctl_word[mfsb_pkg::CF_APP_RESET_OK] = ev_sync.app_reset_ok;
    ctl_word[mfsb_pkg::CF_SUMMARY] = |latch[10:2];
  end

  // write channel: address and data accepted in either order
  localparam int ADDR_LO_W = mfsb_pkg::ADDR_W - 2;
  logic aw_held;
  logic w_held;
  logic [ADDR_LO_W-1:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;

  assign s_axi_awready_o = ~aw_held & ~bvalid;
  assign s_axi_wready_o = ~w_held & ~bvalid;

  wire logic aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  wire logic w_fire = s_axi_wvalid_i & s_axi_wready_o;
  wire logic have_aw = aw_held | aw_fire;
  wire logic have_w = w_held | w_fire;
  wire logic do_write = have_aw & have_w;
  wire logic [ADDR_LO_W-1:0] wr_idx = aw_held ? aw_idx : s_axi_awaddr_i[mfsb_pkg::ADDR_W-1:2];
  wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata_i;
  wire logic [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  wire logic wr_hi_zero = aw_held ? 1'b1 : (s_axi_awaddr_i[31:mfsb_pkg::ADDR_W] == '0);
  logic aw_hi_ok;
  wire logic held_hi_ok = aw_held ? aw_hi_ok : 1'b1;

  // only config-two and algorithm control are writable; fault words ignore writes
  wire logic wr_cfg = do_write & (wr_idx == mfsb_pkg::IDX_GD_CONFIG_TWO) & wr_hi_zero & held_hi_ok;
  wire logic wr_algo = do_write & (wr_idx == mfsb_pkg::IDX_ALGO_CTRL) & wr_hi_zero & held_hi_ok;
  wire logic wr_ro = do_write & ((wr_idx == mfsb_pkg::IDX_DRIVER_FAULT) |
                     (wr_idx == mfsb_pkg::IDX_CTRL_FAULT) | (wr_idx == mfsb_pkg::IDX_SYS_ONE) |
                     (wr_idx == mfsb_pkg::IDX_SYS_TWO) | (wr_idx == mfsb_pkg::IDX_SYS_THREE));
  wire logic [1:0] next_bresp = (wr_cfg | wr_algo | (wr_ro & wr_hi_zero & held_hi_ok)) ?
                                mfsb_pkg::RESP_OKAY : mfsb_pkg::RESP_SLVERR;

  assign clear_req = wr_algo & wr_strb[3] & wr_data[mfsb_pkg::ALGO_CLEAR_ALL];

  logic [31:0] cfg_two;
  logic [31:0] next_cfg_two;
  always_comb begin
    next_cfg_two = cfg_two;
    for (int b = 0; b < 4; b++) begin
      if (wr_cfg && wr_strb[b]) begin
        next_cfg_two[b*8 +: 8] = wr_data[b*8 +: 8];
      end
    end
    next_cfg_two = next_cfg_two & mfsb_pkg::GD_CONFIG_TWO_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      aw_hi_ok <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      s_axi_bresp_o <= mfsb_pkg::RESP_OKAY;
      cfg_two <= mfsb_pkg::RST_GD_CONFIG_TWO;
      clear_all_faults_o <= 1'b0;
    end else begin
      clear_all_faults_o <= clear_req;
      cfg_two <= next_cfg_two;
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        s_axi_bresp_o <= next_bresp;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_idx <= s_axi_awaddr_i[mfsb_pkg::ADDR_W-1:2];
          aw_hi_ok <= (s_axi_awaddr_i[31:mfsb_pkg::ADDR_W] == '0);
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (bvalid && s_axi_bready_i) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid_o = bvalid;
  assign gd_config_two_o = cfg_two;

  // read channel: one read at a time, answer one cycle after address
  logic rvalid;
  assign s_axi_arready_o = ~rvalid;
  wire logic ar_fire = s_axi_arvalid_i & s_axi_arready_o;
  wire logic [ADDR_LO_W-1:0] rd_idx = s_axi_araddr_i[mfsb_pkg::ADDR_W-1:2];
  wire logic rd_hi_zero = (s_axi_araddr_i[31:mfsb_pkg::ADDR_W] == '0);
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_hit = rd_hi_zero;
    case (rd_idx)
      mfsb_pkg::IDX_GD_CONFIG_TWO: rd_word = cfg_two;
      mfsb_pkg::IDX_DRIVER_FAULT: rd_word = drv_word;
      mfsb_pkg::IDX_CTRL_FAULT: rd_word = ctl_word;
      mfsb_pkg::IDX_SYS_ONE: rd_word = sys_sync.word_one;
      mfsb_pkg::IDX_SYS_TWO: rd_word = sys_sync.word_two;
      mfsb_pkg::IDX_SYS_THREE: rd_word = sys_sync.word_three;
      // algorithm control is write-only: reads as zero
      mfsb_pkg::IDX_ALGO_CTRL: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= mfsb_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      s_axi_rdata_o <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp_o <= rd_hit ? mfsb_pkg::RESP_OKAY : mfsb_pkg::RESP_SLVERR;
    end else if (rvalid && s_axi_rready_i) begin
      rvalid <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid;

endmodule : mfsb_bank
`default_nettype wire

// ### mfsb_bank_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mfsb_bank_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire mfsb_pkg::mfsb_events_t events_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic clear_all_faults_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] ra;
  logic [31:0] wa;
  wire logic rd_drv = s_axi_rvalid_o && ra == 32'h0000_0380;
  wire logic rd_ctl = s_axi_rvalid_o && ra == 32'h0000_0388;
  // addresses are held here so read data can be judged against the word it came from
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ra <= '0;
      wa <= '0;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) ra <= s_axi_araddr_i;
      if (s_axi_awvalid_i && s_axi_awready_o) wa <= s_axi_awaddr_i;
    end
  end
  property p_drv_sum;
    rd_drv |-> s_axi_rdata_o[31] == |s_axi_rdata_o[28:24];
  endproperty
  a_drv_sum: assert property (p_drv_sum) else $error("driver summary wrong");
  property p_ctl_sum;
    rd_ctl |-> s_axi_rdata_o[31] == |s_axi_rdata_o[29:16];
  endproperty
  a_ctl_sum: assert property (p_ctl_sum) else $error("controller summary wrong");
  property p_any_lock;
    rd_ctl |-> s_axi_rdata_o[20] == |s_axi_rdata_o[23:21];
  endproperty
  a_any_lock: assert property (p_any_lock) else $error("lock bit wrong");
  // live bits are judged only when the detector level one and six cycles back agree, a span that covers the sync delay
  property p_power_up;
    $rose(s_axi_rvalid_o) && ra == 32'h0000_0380 &&
    $past(events_i.power_up_seen, 1) == $past(events_i.power_up_seen, 6)
    |-> s_axi_rdata_o[30] != $past(events_i.power_up_seen, 1);
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up bit wrong");
  property p_selftest_enabled;
    $rose(s_axi_rvalid_o) && ra == 32'h0000_0388 &&
    $past(events_i.selftest_enabled, 1) == $past(events_i.selftest_enabled, 6)
    |-> s_axi_rdata_o[2] == $past(events_i.selftest_enabled, 1);
  endproperty
  a_selftest_enabled: assert property (p_selftest_enabled) else $error("selftest enable bit wrong");
  property p_fault_wr;
    s_axi_bvalid_o && (wa == 32'h0000_0380 || wa == 32'h0000_0388) |-> s_axi_bresp_o == mfsb_pkg::RESP_OKAY;
  endproperty
  a_fault_wr: assert property (p_fault_wr) else $error("fault word write refused");
  property p_far_addr;
    s_axi_rvalid_o && ra[31:10] != 22'h0 |-> s_axi_rresp_o == mfsb_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0;
  endproperty
  a_far_addr: assert property (p_far_addr) else $error("reserved read answered");
  property p_clr_pulse;
    clear_all_faults_o |=> !clear_all_faults_o;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
endmodule : mfsb_bank_monitor
`default_nettype wire

// ### mfsb_pkg.sv
package mfsb_pkg;

  // printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] IDX_GD_CONFIG_TWO = 8'hae;
  localparam logic [7:0] IDX_DRIVER_FAULT = 8'he0;
  localparam logic [7:0] IDX_CTRL_FAULT = 8'he2;
  localparam logic [7:0] IDX_SYS_ONE = 8'he4;
  localparam logic [7:0] IDX_ALGO_CTRL = 8'he6;
  localparam logic [7:0] IDX_SYS_TWO = 8'hea;
  localparam logic [7:0] IDX_SYS_THREE = 8'hec;
  localparam int ADDR_W = 10;

  localparam logic [31:0] RST_GD_CONFIG_TWO = 32'h0000_0000;
  localparam logic [31:0] GD_CONFIG_TWO_MASK = 32'h8000_0000;

  // driver fault word bit positions
  localparam int DF_SUMMARY = 31;
  localparam int DF_POWER_UP = 30;
  localparam int DF_SWITCH_OC = 28;
  localparam int DF_SHUNT_OC = 27;
  localparam int DF_BOOT_LOW = 26;
  localparam int DF_GATE_LOW = 25;
  localparam int DF_SHUTDOWN = 24;

  // controller fault word bit positions
  localparam int CF_SUMMARY = 31;
  localparam int CF_IPD_RATE = 29;
  localparam int CF_IPD_INTERVAL = 28;
  localparam int CF_ABNORMAL_SPEED_LOCK = 23;
  localparam int CF_SYNC_LOST = 22;
  localparam int CF_MOTOR_ABSENT = 21;
  localparam int CF_ANY_LOCK = 20;
  localparam int CF_CYCLE_LIMIT = 19;
  localparam int CF_LOCK_LIMIT = 18;
  localparam int CF_SUPPLY_LOW = 17;
  localparam int CF_SUPPLY_HIGH = 16;
  localparam int CF_SELFTEST_EN = 2;
  localparam int CF_SELFTEST_OK = 1;
  localparam int CF_APP_RESET_OK = 0;

  localparam int ALGO_CLEAR_ALL = 29;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // raw detector levels, one per flag: fourteen faults and four status levels
  typedef struct packed {
    logic power_up_seen;
    logic switch_drop_overcurrent;
    logic shunt_overcurrent;
    logic bootstrap_low_supply;
    logic gate_supply_low;
    logic shutdown_pin;
    logic position_detect_rate_error;
    logic position_detect_interval_error;
    logic abnormal_speed_lock;
    logic sync_lost_lock;
    logic motor_absent;
    logic cycle_current_limit;
    logic lock_current_limit;
    logic supply_too_low;
    logic supply_too_high;
    logic selftest_enabled;
    logic selftest_passed;
    logic app_reset_ok;
  } mfsb_events_t;

  typedef struct packed {
    logic [31:0] word_one;
    logic [31:0] word_two;
    logic [31:0] word_three;
  } mfsb_sys_t;

endpackage : mfsb_pkg

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] A_DRV = 32'h0000_0380;
  localparam logic [31:0] A_CTL = 32'h0000_0388;
  localparam logic [31:0] A_ALG = 32'h0000_0398;
  localparam logic [31:0] A_CFG = 32'h0000_02b8;
  localparam logic [1:0] OK = mfsb_pkg::RESP_OKAY;
  localparam logic [1:0] SE = mfsb_pkg::RESP_SLVERR;
  logic core_clk_i, rst_i, awv, wv, bre, arv, rre, awr, wr_o, bv, arr, rv, clr;
  logic [31:0] awa, wd, ara, rdo, cfg, ld, lc, x;
  logic [3:0] ws;
  logic [1:0] br, rr;
  mfsb_pkg::mfsb_events_t ev;
  mfsb_pkg::mfsb_sys_t sys;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  mfsb_bank mfsb_bank_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .events_i(ev), .sys_i(sys),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .gd_config_two_o(cfg), .clear_all_faults_o(clr));
  function automatic logic [31:0] fd(input logic [17:0] e);
    return {3'h0, e[16:12], 24'h0};
  endfunction : fd
  function automatic logic [31:0] fc(input logic [17:0] e);
    return {2'h0, e[11:10], 4'h0, e[9:7], 1'b0, e[6:3], 16'h0};
  endfunction : fc
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge core_clk_i);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wr_o === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bre <= 1'b0;
    ck("bresp", {30'h0, er}, {30'h0, br});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arv && arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rre <= 1'b0;
    ck("rdata", e, rdo);
    ck("rresp", {30'h0, er}, {30'h0, rr});
  endtask : rd
  // the wait covers the two-flop sync plus the latch stage
  task automatic see();
    repeat (6) @(posedge core_clk_i);
    ld = ld | fd(ev);
    lc = lc | fc(ev);
    x = ld | {|ld, !ev[17], 30'h0};
    rd(A_DRV, x, OK);
    x = lc | {|lc, 10'h0, |lc[23:21], 17'h0, ev[2:0]};
    rd(A_CTL, x, OK);
  endtask : see
  // a detector still high re-latches at once, so the model keeps what is live
  task automatic clear();
    wr(A_ALG, 32'h2000_0000, 4'hf, OK);
    ld = fd(ev);
    lc = fc(ev);
  endtask : clear
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    rst_i = 1'b1;
    {awv, wv, bre, arv, rre} = '0;
    {awa, wd, ara, ws} = '0;
    ev = '0;
    void'($urandom(32'h09f3));
    sys = {$urandom, $urandom, $urandom};
    ld = '0;
    lc = '0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(A_CFG, 32'h0, OK);
    rd(32'h0000_0390, sys.word_one, OK);
    rd(32'h0000_03a8, sys.word_two, OK);
    rd(32'h0000_03b0, sys.word_three, OK);
    see();
    rd(32'h0000_03a0, 32'h0, SE);
    rd(32'h0010_0380, 32'h0, SE);
    wr(32'h0000_03a0, $urandom, 4'hf, SE);
    wr(A_DRV, 32'hffff_ffff, 4'hf, OK);
    wr(A_CTL, 32'hffff_ffff, 4'hf, OK);
    for (int i = 3; i < 17; i++) begin
      ev <= 18'h1 << i;
      see();
      ev <= '0;
      see();
      clear();
      see();
    end
    for (int r = 0; r < 10; r++) begin
      ev <= 18'($urandom);
      see();
      clear();
      see();
    end
    x = $urandom;
    wr(A_CFG, x, 4'hf, OK);
    rd(A_CFG, x & mfsb_pkg::GD_CONFIG_TWO_MASK, OK);
    wr(A_CFG, ~x, 4'h7, OK);
    rd(A_CFG, x & mfsb_pkg::GD_CONFIG_TWO_MASK, OK);
    ck("config out", x & mfsb_pkg::GD_CONFIG_TWO_MASK, cfg);
    rd(A_ALG, 32'h0, OK);
    test_done();
  end
endmodule : tb
bind mfsb_bank mfsb_bank_monitor mfsb_bank_monitor_i (.core_clk_i, .rst_i, .events_i, .s_axi_awaddr_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .clear_all_faults_o);
`default_nettype wire
